// ### hw/icr_pkg.sv
// Constants, layouts and types of the inquiry command responder
package icr_pkg;
    // Command block and opcodes
    localparam logic [7:0]  OP_INQUIRY    = 8'h12;
    localparam logic [7:0]  OP_REQ_SENSE  = 8'h03;
    localparam int          VPD_BIT       = 0;
    // Completion status and sense
    localparam logic [7:0]  ST_GOOD       = 8'h00;
    localparam logic [7:0]  ST_CHECK      = 8'h02;
    localparam logic [3:0]  KEY_ILLEGAL   = 4'h5;
    localparam logic [7:0]  ASC_BAD_FIELD = 8'h24;
    localparam logic [7:0]  ASC_BAD_LUN   = 8'h25;
    // Response lengths and standard data bytes
    localparam logic [15:0] LEN_STD       = 16'h00A4;
    localparam logic [15:0] LEN_VPD_LIST  = 16'h000E;
    localparam logic [15:0] LEN_VPD_HDR   = 16'h0004;
    localparam logic [2:0]  QUAL_PRESENT  = 3'h0;
    localparam logic [2:0]  QUAL_ABSENT   = 3'h3;
    localparam logic [4:0]  DEV_TYPE_DISK = 5'h00;
    localparam logic [7:0]  STD_B1        = 8'h00;
    localparam logic [7:0]  STD_VERSION   = 8'h06;
    localparam logic [7:0]  STD_B3        = 8'h12;
    localparam logic [7:0]  STD_ADD_LEN   = 8'h9F;
    localparam logic [7:0]  STD_B5        = 8'h01;
    localparam logic [7:0]  STD_B6        = 8'h10;
    localparam logic [7:0]  STD_B7        = 8'h02;
    localparam logic [7:0]  B_VENDOR      = 8'h08;
    localparam logic [7:0]  B_PRODUCT     = 8'h10;
    localparam logic [7:0]  B_REV         = 8'h20;
    localparam logic [7:0]  B_SERIAL      = 8'h24;
    localparam logic [7:0]  B_RSVD        = 8'h2C;
    localparam logic [7:0]  B_HARD_AL     = 8'h60;
    localparam logic [7:0]  B_ACQ_AL      = 8'h61;
    localparam logic [7:0]  VPD_LIST_LEN  = 8'h0A;
    localparam logic [79:0] VPD_LIST      = 80'h0003_8083_8687_888A_B1D2;
    localparam int          VPD_COUNT     = 10;
    // APB register byte addresses
    localparam logic [7:0]  A_REVISION    = 8'h00;
    localparam logic [7:0]  A_SERIAL_HI   = 8'h04;
    localparam logic [7:0]  A_SERIAL_LO   = 8'h08;
    localparam logic [7:0]  A_LOOP_ADDR   = 8'h0C;
    localparam logic [7:0]  A_STATUS      = 8'h10;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  flags;
        logic [7:0]  page;
        logic [15:0] alloc;
        logic [7:0]  control;
    } icr_cdb_t;

    typedef struct packed {
        logic       fwd;
        logic [7:0] status;
        logic [3:0] key;
        logic [7:0] asc;
    } icr_done_t;

    typedef enum logic [1:0] {MODE_STD, MODE_LIST, MODE_HDR} icr_mode_t;
endpackage

// ### hw/icr_top.sv
// Inquiry command decoder and response streamer with APB registers
`timescale 1ns/100ps

// Behaviour
// RQ1 - Decode opcode, VPD flag, page, length, control (the control byte is not decoded here)
// RQ2 - VPD 0, page 0 returns standard data
// RQ3 - VPD 0, nonzero page gives check condition
// RQ4 - VPD 1 returns matching vital data page (listed pages other than 00h return only their 4-byte header, page length 0; unlisted pages give check condition)
// RQ5 - Zero length sends nothing, still completes
// RQ6 - Send smaller of available and allocated
// RQ7 - Pending unit attention neither blocks nor clears
// RQ8 - Taken at once, never queued
// RQ9 - Revision writable; other content fixed (serial number and loop addresses are also APB writable here)
// RQ10 - Byte 0 identical on every page
// RQ11 - Absent unit reports qualifier 011b
// RQ12 - Bad unit fails all but inquiry, sense
// RQ13 - Additional length is 159
// RQ14 - Version 6, format 2, hierarchical set
// RQ15 - Protection, multiport, queuing reported set
// RQ16 - Removable, array, access, copy, asymmetric zero
// RQ17 - Port bit shows receiving port
// RQ18 - Vendor, product, revision, serial; reserved zero
// RQ19 - Hard and acquired loop address bytes
// RQ20 - Page list header: 00h, 0, 0Ah
// RQ21 - Ten supported codes ascending
// RQ22 - Allocation length upper byte first
module icr_top #(
    parameter logic [63:0]  VENDOR_ID  = 64'h5645_4E44_4F52_2020, // Arbitrary value
    parameter logic [127:0] PRODUCT_ID = 128'h5354_4F52_4147_4520_554E_4954_2020_2020 // Arbitrary
) (
    input  wire logic             REF_CLK,
    input  wire logic             RST_N,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    input  wire logic             CMD_VALID,
    input  wire icr_pkg::icr_cdb_t CMD_CDB,
    input  wire logic             CMD_PORT,
    input  wire logic             CMD_LUN_OK,
    output logic                  CMD_READY,
    output logic                  DIN_VALID,
    output logic      [7:0]       DIN_DATA,
    output logic                  DIN_LAST,
    input  wire logic             DIN_READY,
    output logic                  DONE_VALID,
    output icr_pkg::icr_done_t    DONE_INFO
);
    if (PRODUCT_ID == '0 || VENDOR_ID == '0) begin : g_chk
        $error("icr_top: identification strings must not be empty");
    end

    typedef enum logic [1:0] {S_IDLE, S_SEND, S_FIN} icr_state_t;

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]          rst_sync_reg;
    logic                rst_n;
    icr_state_t          state_reg;
    icr_pkg::icr_mode_t  mode_reg;
    logic [15:0]         len_reg;
    logic [15:0]         idx_reg;
    logic [7:0]          page_reg;
    logic                port_reg;
    logic [2:0]          qual_reg;
    logic                ready_reg;
    logic                din_valid_reg;
    logic [7:0]          din_data_reg;
    logic                din_last_reg;
    logic [15:0]         out_idx_reg;
    logic                done_valid_reg;
    icr_pkg::icr_done_t  done_reg;
    icr_pkg::icr_done_t  take_done_next;
    logic [31:0]         rev_reg;
    logic [63:0]         serial_reg;
    logic [31:0]         loop_reg;
    logic [31:0]         prdata_reg;
    logic                pready_reg;
    logic                pslverr_reg;
    logic [15:0]         cmd_count_reg;
    logic                take;
    logic                is_inq;
    logic                vpd;
    logic                fail_now;
    logic                advance;
    icr_pkg::icr_mode_t  take_mode;
    logic [15:0]         avail;
    logic [15:0]         send_len;
    logic [7:0]          cur_byte;
    logic                addr_ok;
    logic [31:0]         rd_word;

    function automatic logic [7:0] pick(input logic [127:0] v, input logic [7:0] k);
        pick = v[127 - 8 * k[3:0] -: 8];
    endfunction

    function automatic logic listed(input logic [7:0] code);
        listed = 1'b0;
        for (int i = 0; i < icr_pkg::VPD_COUNT; i++) begin
            if (pick({icr_pkg::VPD_LIST, 48'h0}, 8'(i)) == code) begin
                listed = 1'b1;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    assign take    = CMD_VALID && ready_reg;                       // RQ8 RQ7
    assign is_inq  = CMD_CDB.opcode == icr_pkg::OP_INQUIRY;        // RQ1
    assign vpd     = CMD_CDB.flags[icr_pkg::VPD_BIT];              // RQ1

    always_comb begin
        take_done_next        = '0;
        take_done_next.status = icr_pkg::ST_GOOD;
        take_mode             = icr_pkg::MODE_STD;                 // RQ2
        avail                 = icr_pkg::LEN_STD;
        fail_now              = 1'b0;
        if (!is_inq) begin
            take_done_next.fwd = 1'b1;
            if (!CMD_LUN_OK && CMD_CDB.opcode != icr_pkg::OP_REQ_SENSE) begin
                take_done_next.fwd    = 1'b0;                      // RQ12
                take_done_next.status = icr_pkg::ST_CHECK;
                take_done_next.key    = icr_pkg::KEY_ILLEGAL;
                take_done_next.asc    = icr_pkg::ASC_BAD_LUN;
            end
        end else if (!vpd && CMD_CDB.page != 8'h00) begin
            fail_now = 1'b1;                                       // RQ3
        end else if (vpd && CMD_CDB.page == 8'h00) begin
            take_mode = icr_pkg::MODE_LIST;                        // RQ4
            avail     = icr_pkg::LEN_VPD_LIST;
        end else if (vpd) begin
            take_mode = icr_pkg::MODE_HDR;                         // RQ4
            avail     = icr_pkg::LEN_VPD_HDR;
            fail_now  = !listed(CMD_CDB.page);
        end
        if (fail_now) begin
            take_done_next.status = icr_pkg::ST_CHECK;
            take_done_next.key    = icr_pkg::KEY_ILLEGAL;
            take_done_next.asc    = icr_pkg::ASC_BAD_FIELD;
        end
        // Alloc field is held upper byte first
        send_len = (CMD_CDB.alloc < avail) ? CMD_CDB.alloc : avail; // RQ6 RQ22
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response byte generator
    always_comb begin
        cur_byte = 8'h00;
        if (idx_reg[15:8] != 8'h00) begin
            cur_byte = 8'h00;
        end else if (idx_reg[7:0] == 8'h00) begin
            cur_byte = {qual_reg, icr_pkg::DEV_TYPE_DISK};         // RQ10 RQ11
        end else if (mode_reg == icr_pkg::MODE_STD) begin
            case (idx_reg[7:0])
                8'h01: cur_byte = icr_pkg::STD_B1;                 // RQ16
                8'h02: cur_byte = icr_pkg::STD_VERSION;            // RQ14
                8'h03: cur_byte = icr_pkg::STD_B3;                 // RQ14
                8'h04: cur_byte = icr_pkg::STD_ADD_LEN;            // RQ13
                8'h05: cur_byte = icr_pkg::STD_B5;                 // RQ15 RQ16
                8'h06: cur_byte = icr_pkg::STD_B6 | {7'h0, port_reg}; // RQ15 RQ17
                8'h07: cur_byte = icr_pkg::STD_B7;                 // RQ15
                icr_pkg::B_HARD_AL: cur_byte = port_reg ? loop_reg[23:16] : loop_reg[7:0]; // RQ19
                icr_pkg::B_ACQ_AL:  cur_byte = port_reg ? loop_reg[31:24] : loop_reg[15:8]; // RQ19
                default: begin
                    if (idx_reg[7:0] >= icr_pkg::B_RSVD) begin
                        cur_byte = 8'h00;                          // RQ18
                    end else if (idx_reg[7:0] >= icr_pkg::B_SERIAL) begin
                        cur_byte = pick({serial_reg, 64'h0}, idx_reg[7:0] - icr_pkg::B_SERIAL);
                    end else if (idx_reg[7:0] >= icr_pkg::B_REV) begin
                        cur_byte = pick({rev_reg, 96'h0}, idx_reg[7:0] - icr_pkg::B_REV); // RQ9
                    end else if (idx_reg[7:0] >= icr_pkg::B_PRODUCT) begin
                        cur_byte = pick(PRODUCT_ID, idx_reg[7:0] - icr_pkg::B_PRODUCT); // RQ18
                    end else if (idx_reg[7:0] >= icr_pkg::B_VENDOR) begin
                        cur_byte = pick({VENDOR_ID, 64'h0}, idx_reg[7:0] - icr_pkg::B_VENDOR);
                    end
                end
            endcase
        end else begin
            case (idx_reg[7:0])
                8'h01:   cur_byte = page_reg;                      // RQ20 RQ4
                8'h02:   cur_byte = 8'h00;
                8'h03:   cur_byte = (mode_reg == icr_pkg::MODE_LIST) ?
                                    icr_pkg::VPD_LIST_LEN : 8'h00; // RQ20
                default: cur_byte = pick({icr_pkg::VPD_LIST, 48'h0}, idx_reg[7:0] - 8'h04); // RQ21
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencing
    assign advance = !din_valid_reg || DIN_READY;

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= S_IDLE;
            ready_reg     <= 1'b0;
            mode_reg      <= icr_pkg::MODE_STD;
            len_reg       <= 16'h0000;
            idx_reg       <= 16'h0000;
            page_reg      <= 8'h00;
            port_reg      <= 1'b0;
            qual_reg      <= icr_pkg::QUAL_PRESENT;
            cmd_count_reg <= 16'h0000;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    ready_reg <= 1'b1;
                    if (take) begin
                        ready_reg     <= 1'b0;
                        cmd_count_reg <= cmd_count_reg + 16'h0001;
                        mode_reg      <= take_mode;
                        len_reg       <= send_len;
                        idx_reg       <= 16'h0000;
                        page_reg      <= CMD_CDB.page;
                        port_reg      <= CMD_PORT;
                        qual_reg      <= CMD_LUN_OK ? icr_pkg::QUAL_PRESENT
                                                    : icr_pkg::QUAL_ABSENT; // RQ11
                        // Zero length still completes
                        if (!is_inq || fail_now || send_len == 16'h0000) begin
                            state_reg <= S_FIN;                    // RQ5
                        end else begin
                            state_reg <= S_SEND;
                        end
                    end
                end
                S_SEND: begin
                    if (advance) begin
                        if (idx_reg < len_reg) begin
                            idx_reg <= idx_reg + 16'h0001;
                        end else begin
                            state_reg <= S_FIN;                    // RQ6
                        end
                    end
                end
                S_FIN: begin
                    state_reg <= S_IDLE;
                    ready_reg <= 1'b1;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Data-in stream
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            din_valid_reg <= 1'b0;
            din_data_reg  <= 8'h00;
            din_last_reg  <= 1'b0;
            out_idx_reg   <= 16'h0000;
        end else if (state_reg == S_SEND && advance) begin
            din_valid_reg <= idx_reg < len_reg;                    // RQ6
            din_data_reg  <= cur_byte;
            din_last_reg  <= idx_reg + 16'h0001 == len_reg;
            out_idx_reg   <= idx_reg;
        end else if (DIN_READY) begin
            din_valid_reg <= 1'b0;
        end
    end

    // Completion report
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            done_valid_reg <= 1'b0;
            done_reg       <= '0;
        end else begin
            done_valid_reg <= state_reg == S_FIN;
            if (take) begin
                done_reg <= take_done_next;                        // RQ3 RQ12
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    assign addr_ok = PADDR == icr_pkg::A_REVISION || PADDR == icr_pkg::A_SERIAL_HI ||
                     PADDR == icr_pkg::A_SERIAL_LO || PADDR == icr_pkg::A_LOOP_ADDR ||
                     PADDR == icr_pkg::A_STATUS;

    always_comb begin
        case (PADDR)
            icr_pkg::A_REVISION:  rd_word = rev_reg;
            icr_pkg::A_SERIAL_HI: rd_word = serial_reg[63:32];
            icr_pkg::A_SERIAL_LO: rd_word = serial_reg[31:0];
            icr_pkg::A_LOOP_ADDR: rd_word = loop_reg;
            icr_pkg::A_STATUS:    rd_word = {cmd_count_reg, 14'h0000, state_reg};
            default:              rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= PSEL && PENABLE && !pready_reg;
            pslverr_reg <= PSEL && PENABLE && !pready_reg && !addr_ok;
            if (PSEL && PENABLE && !pready_reg && !PWRITE) begin
                prdata_reg <= rd_word;
            end
        end
    end

    // Revision changes after a code download
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rev_reg    <= 32'h3030_3030;
            serial_reg <= 64'h3030_3030_3030_3030;
            loop_reg   <= 32'h0000_0000;
        end else if (PSEL && PENABLE && pready_reg && PWRITE) begin
            case (PADDR)
                icr_pkg::A_REVISION:  rev_reg <= PWDATA;           // RQ9
                icr_pkg::A_SERIAL_HI: serial_reg[63:32] <= PWDATA;
                icr_pkg::A_SERIAL_LO: serial_reg[31:0] <= PWDATA;
                icr_pkg::A_LOOP_ADDR: loop_reg <= PWDATA;
                default: ;
            endcase
        end
    end

    assign PRDATA     = prdata_reg;
    assign PREADY     = pready_reg;
    assign PSLVERR    = pslverr_reg;
    assign CMD_READY  = ready_reg;
    assign DIN_VALID  = din_valid_reg;
    assign DIN_DATA   = din_data_reg;
    assign DIN_LAST   = din_last_reg;
    assign DONE_VALID = done_valid_reg;
    assign DONE_INFO  = done_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!rst_n);

    sequence s_take_bad_page;
        take && is_inq && !vpd && CMD_CDB.page != 8'h00;
    endsequence
    sequence s_check_done;
        DONE_VALID && DONE_INFO.status == icr_pkg::ST_CHECK &&
        DONE_INFO.asc == icr_pkg::ASC_BAD_FIELD;
    endsequence
    sequence s_take_zero;
        take && is_inq && CMD_CDB.alloc == 16'h0000;
    endsequence

    a_bad_page_check: assert property (s_take_bad_page |-> ##2 s_check_done) // RQ3
        else $error("bad page not failed");
    a_zero_alloc_quiet: assert property (s_take_zero |-> (!DIN_VALID)[*3] ##0 DONE_VALID) // RQ5
        else $error("zero length sent data");
    a_len_bound: assert property (DIN_VALID |-> out_idx_reg < len_reg) // RQ6
        else $error("sent beyond length");
    a_last_to_done: assert property (DIN_VALID && DIN_READY && DIN_LAST // RQ6
        |-> ##[1:3] DONE_VALID)
        else $error("no completion after last byte");
    // Ready rises one edge after the internal reset lets go
    a_idle_ready: assert property (state_reg == S_IDLE && $past(state_reg) == S_IDLE && // RQ8
        $past(rst_n) |-> CMD_READY)
        else $error("idle but not ready");
    a_byte0_same: assert property (DIN_VALID && out_idx_reg == 16'h0000 // RQ10
        |-> DIN_DATA[4:0] == icr_pkg::DEV_TYPE_DISK && DIN_DATA[7:5] == qual_reg)
        else $error("byte 0 wrong");
    a_qual_absent: assert property (take && is_inq && !CMD_LUN_OK // RQ11
        |=> qual_reg == icr_pkg::QUAL_ABSENT)
        else $error("absent unit qualifier");
    a_port_bit: assert property (DIN_VALID && mode_reg == icr_pkg::MODE_STD && // RQ17
        out_idx_reg == 16'h0006 |-> DIN_DATA[0] == port_reg)
        else $error("port bit wrong");
    a_add_len: assert property (DIN_VALID && mode_reg == icr_pkg::MODE_STD && // RQ13
        out_idx_reg == 16'h0004 |-> DIN_DATA == 8'h9F)
        else $error("additional length wrong");
    a_list_len: assert property (DIN_VALID && mode_reg == icr_pkg::MODE_LIST && // RQ20
        out_idx_reg == 16'h0003 |-> DIN_DATA == 8'h0A)
        else $error("page list length wrong");
    a_bad_lun_other: assert property (take && !is_inq && !CMD_LUN_OK && // RQ12
        CMD_CDB.opcode != icr_pkg::OP_REQ_SENSE |-> ##2 DONE_VALID &&
        DONE_INFO.status == icr_pkg::ST_CHECK)
        else $error("bad unit not failed");
    a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("apb answer late");
endmodule

// ### verification/icr_host_model.sv
// Initiator model: offers commands and sinks data-in bytes
`timescale 1ns/100ps
module icr_host_model (
    input  wire logic          clk,
    input  wire logic          cmd_ready,
    input  wire logic          din_valid,
    input  wire logic [7:0]    din_data,
    output logic               cmd_valid,
    output icr_pkg::icr_cdb_t  cmd_cdb,
    output logic               cmd_port,
    output logic               cmd_lun_ok,
    output logic               din_ready
);
    logic       slow;
    logic [7:0] rx[$];
    initial begin
        slow = 1'b0;
        cmd_valid = 1'b0;
        cmd_cdb = '0;
        cmd_port = 1'b0;
        cmd_lun_ok = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Stalls every other cycle when slow
    always @(posedge clk) begin
        if (din_valid && din_ready) begin
            rx.push_back(din_data);
        end
        din_ready <= slow ? ~din_ready : 1'b1;
    end
    task automatic send(input logic [7:0] op, fl, pg, input logic [15:0] al,
                        input logic pt, lu);
        @(posedge clk);
        cmd_valid  <= 1'b1;
        cmd_cdb    <= {op, fl, pg, al[15:8], al[7:0], 8'h00};
        cmd_port   <= pt;
        cmd_lun_ok <= lu;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        cmd_cdb   <= ~cmd_cdb;
    endtask
endmodule

// ### verification/inquiry_command_responder_bench.sv
// Testbench for the inquiry command responder
`timescale 1ns/100ps
module inquiry_command_responder_bench;
    logic               REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0]         PADDR, DIN_DATA;
    logic [31:0]        PWDATA, PRDATA, rd;
    logic               CMD_VALID, CMD_PORT, CMD_LUN_OK, CMD_READY, er, DONE_VALID;
    logic               DIN_VALID, DIN_LAST, DIN_READY;
    logic [7:0]         acc;
    icr_pkg::icr_cdb_t  CMD_CDB;
    icr_pkg::icr_done_t DONE_INFO;
    int                 bad_count, comparisons, cycles;
    int                 nbytes, last_pos;
    localparam logic [63:0]  STD_HEAD = 64'h0000_0612_9F01_1002;
    localparam logic [111:0] VPD_PAGE = 112'h0000_000A_0003_8083_8687_888A_B1D2;
    localparam logic [20:0]  BAD_FLD  = {1'b0, 8'h02, 4'h5, 8'h24};

    icr_top i_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CMD_VALID(CMD_VALID), .CMD_CDB(CMD_CDB), .CMD_PORT(CMD_PORT),
        .CMD_LUN_OK(CMD_LUN_OK), .CMD_READY(CMD_READY), .DIN_VALID(DIN_VALID),
        .DIN_DATA(DIN_DATA), .DIN_LAST(DIN_LAST), .DIN_READY(DIN_READY),
        .DONE_VALID(DONE_VALID), .DONE_INFO(DONE_INFO));
    icr_host_model i_host (.clk(REF_CLK), .cmd_ready(CMD_READY), .din_valid(DIN_VALID),
        .din_data(DIN_DATA), .cmd_valid(CMD_VALID), .cmd_cdb(CMD_CDB), .cmd_port(CMD_PORT),
        .cmd_lun_ok(CMD_LUN_OK), .din_ready(DIN_READY));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do @(posedge REF_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic run(input logic [7:0] op, fl, pg, input logic [15:0] al,
                       input logic pt, lu, input int n, input logic [20:0] info);
        int k;
        k = 0;
        nbytes = 0;
        last_pos = 0;
        i_host.rx.delete();
        i_host.send(op, fl, pg, al, pt, lu);
        while (DONE_VALID !== 1'b1 && k < 3000) begin
            @(posedge REF_CLK);
            k++;
        end
        chk(DONE_VALID, 1'b1);
        chk(i_host.rx.size(), n);
        chk(last_pos, n);
        chk({11'h000, DONE_INFO}, {11'h000, info});
    endtask
    // Position of the byte that carried the last flag
    always @(posedge REF_CLK) begin
        if (DIN_VALID === 1'b1 && DIN_READY === 1'b1) begin
            nbytes++;
            if (DIN_LAST === 1'b1) begin
                last_pos = nbytes;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        REF_CLK = 1'b0;
        forever #50 REF_CLK = ~REF_CLK;
    end
    // Hang guard
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        repeat (20) @(posedge REF_CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        apb(1'b1, 8'h00, 32'h3132_3334);
        apb(1'b1, 8'h0C, 32'h4433_2211);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h3132_3334);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({rd[31:1], er}, 32'h0000_0001);
        run(8'h12, 8'h00, 8'h00, 16'h0100, 1'b0, 1'b1, 164, 21'h0);
        for (int i = 0; i < 8; i++) begin
            chk(i_host.rx[i], STD_HEAD[63-8*i -: 8]);
        end
        chk({i_host.rx[32], i_host.rx[33], i_host.rx[34], i_host.rx[35]}, 32'h3132_3334);
        chk({i_host.rx[36], i_host.rx[37], i_host.rx[38], i_host.rx[39]}, 32'h3030_3030);
        acc = 8'h00;
        for (int i = 44; i < 96; i++) begin
            acc = acc | i_host.rx[i];
        end
        chk(acc, 8'h00);
        chk({i_host.rx[96], i_host.rx[97]}, 16'h1122);
        i_host.slow = 1'b1;
        run(8'h12, 8'h00, 8'h00, 16'h0008, 1'b1, 1'b0, 8, 21'h0);
        chk(i_host.rx[0], 8'h60);
        chk(i_host.rx[6], 8'h11);
        run(8'h12, 8'h01, 8'h00, 16'h00FF, 1'b0, 1'b1, 14, 21'h0);
        for (int i = 0; i < 14; i++) begin
            chk(i_host.rx[i], VPD_PAGE[111-8*i -: 8]);
        end
        i_host.slow = 1'b0;
        run(8'h12, 8'h00, 8'h01, 16'h00FF, 1'b0, 1'b1, 0, BAD_FLD);
        run(8'h12, 8'h00, 8'h00, 16'h0000, 1'b0, 1'b1, 0, 21'h0);
        run(8'h12, 8'h01, 8'h83, 16'h0003, 1'b0, 1'b1, 3, 21'h0);
        chk({i_host.rx[0], i_host.rx[1], i_host.rx[2]}, 24'h00_8300);
        run(8'h00, 8'h00, 8'h00, 16'h0000, 1'b0, 1'b0, 0, {1'b0, 8'h02, 4'h5, 8'h25});
        run(8'h03, 8'h00, 8'h00, 16'h0000, 1'b0, 1'b0, 0, {1'b1, 20'h0_0000});
        print_verdict();
    end
endmodule
